/* File: hdl/eeprom_access_controller.sv */
`timescale 1ns/1ps

`include "eeprom_access_params.svh"

module eeprom_access_controller
  import eeprom_access_pkg::*;
#(
  parameter logic [13:0] WRITE_OSC_CYCLES = `WRITE_OSC_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PWR_ON_RST,
  input wire logic IO_WE,
  input wire logic IO_RE,
  input wire logic [1:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  input wire logic GLOBAL_INT_ENABLE,
  input wire logic SELF_PROGRAM_ENABLE,
  input wire logic SLEEP_POWER_DOWN,
  output logic CPU_STALL,
  output logic READY_IRQ,
  output logic OSC_RUN,
  output logic POWER_DOWN_READY
);

  ctrl_state_t st_reg;
  ctrl_state_t st_next;
  logic [7:0] stor_mem [0:`STORAGE_BYTES-1];
  logic timer_done;
  logic ctrl_wr;
  logic write_start;
  logic read_start;
  logic [7:0] ctrl_view;

  // ****************************************************************
  // Write period timer
  // ****************************************************************
  write_timer #(
    .OSC_CYCLES(WRITE_OSC_CYCLES)
  ) u_timer (
    .clk(CLK_SYS),
    .por(PWR_ON_RST),
    .start(write_start),
    .done(timer_done)
  );

  // ****************************************************************
  // Request decode
  // ****************************************************************
  assign ctrl_wr = IO_WE && (IO_ADDR == `REG_CONTROL);
  assign write_start = ctrl_wr && IO_WDATA[`CTRL_STROBE] && st_reg.arm
    && !st_reg.busy && !SELF_PROGRAM_ENABLE;
  assign read_start = ctrl_wr && IO_WDATA[`CTRL_READ] && !st_reg.busy
    && !write_start;
  assign ctrl_view = {4'h0, st_reg.rie, st_reg.arm, st_reg.busy,
    1'b0};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    // Arm window countdown
    if (st_reg.arm_cnt != 3'h0) begin
      st_next.arm_cnt = st_reg.arm_cnt - 3'h1;
    end
    // Stall countdown
    if (st_reg.stall_cnt != 3'h0) begin
      st_next.stall_cnt = st_reg.stall_cnt - 3'h1;
    end
    // Register writes
    if (IO_WE) begin
      unique case (IO_ADDR)
        `REG_ADDR_LOW: begin
          if (!st_reg.busy) begin
            st_next.addr[7:0] = IO_WDATA;
          end
        end
        `REG_ADDR_HIGH: begin
          if (!st_reg.busy) begin
            st_next.addr[11:8] = IO_WDATA[`ADDR_HIGH_MSB:0];
          end
        end
        `REG_DATA: begin
          st_next.data = IO_WDATA;
        end
        `REG_CONTROL: begin
          st_next.rie = IO_WDATA[`CTRL_RIE];
          if (IO_WDATA[`CTRL_ARM] && !st_reg.arm) begin
            st_next.arm_cnt = `ARM_CYCLES;
          end
        end
      endcase
    end
    // Self-timed write start
    if (write_start) begin
      st_next.busy = 1'b1;
      st_next.wr_addr = st_reg.addr;
      st_next.wr_data = st_reg.data;
      st_next.stall_cnt = `WRITE_STALL_CYCLES;
    end
    // Immediate read
    if (read_start) begin
      st_next.data = stor_mem[st_reg.addr];
      st_next.stall_cnt = `READ_STALL_CYCLES;
    end
    // Write period end
    if (timer_done) begin
      st_next.busy = 1'b0;
    end
    st_next.arm = st_next.arm_cnt != 3'h0;
    st_next.stall = st_next.stall_cnt != 3'h0;
    st_next.irq = st_next.rie && GLOBAL_INT_ENABLE
      && !st_next.busy;
    st_next.osc_run = st_next.busy;
    st_next.pd_ready = SLEEP_POWER_DOWN && !st_next.busy;
    // Register reads
    st_next.rdata = 8'h00;
    if (IO_RE) begin
      unique case (IO_ADDR)
        `REG_ADDR_LOW: st_next.rdata = st_reg.addr[7:0];
        `REG_ADDR_HIGH: st_next.rdata = {4'h0, st_reg.addr[11:8]};
        `REG_DATA: st_next.rdata = st_reg.data;
        `REG_CONTROL: st_next.rdata = ctrl_view;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (PWR_ON_RST) begin
      st_reg <= '0;
      st_reg.addr <= `ADDR_RESET;
      st_reg.data <= `DATA_RESET;
    end else if (RST) begin
      st_reg <= '0;
      st_reg.addr <= `ADDR_RESET;
      st_reg.data <= `DATA_RESET;
      st_reg.busy <= st_next.busy;
      st_reg.wr_addr <= st_reg.wr_addr;
      st_reg.wr_data <= st_reg.wr_data;
      st_reg.osc_run <= st_next.busy;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Storage array
  // ****************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (timer_done && !PWR_ON_RST) begin
      stor_mem[st_reg.wr_addr] <= st_reg.wr_data;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign IO_RDATA = st_reg.rdata;
  assign CPU_STALL = st_reg.stall;
  assign READY_IRQ = st_reg.irq;
  assign OSC_RUN = st_reg.osc_run;
  assign POWER_DOWN_READY = st_reg.pd_ready;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_addr_high_reserved;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    IO_RE && IO_ADDR == `REG_ADDR_HIGH |=> IO_RDATA[7:4] == 4'h0;
  endproperty
  a_addr_high_reserved: assert property (p_addr_high_reserved)
    else $error("address high reserved bits read nonzero");

  property p_ctrl_reserved;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    IO_RE && IO_ADDR == `REG_CONTROL |=> IO_RDATA[7:4] == 4'h0
      && IO_RDATA[0] == 1'b0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("control reserved bits read nonzero");

  property p_arm_timeout;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    $rose(st_reg.arm) |-> st_reg.arm [*4] ##1 !st_reg.arm;
  endproperty
  a_arm_timeout: assert property (p_arm_timeout)
    else $error("arm did not clear after four cycles");

  property p_write_start;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    ctrl_wr && IO_WDATA[`CTRL_STROBE] && st_reg.arm && !st_reg.busy
      && !SELF_PROGRAM_ENABLE |=> st_reg.busy;
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("armed strobe did not start a write");

  property p_strobe_unarmed;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    ctrl_wr && IO_WDATA[`CTRL_STROBE] && !st_reg.arm && !st_reg.busy
      |=> !st_reg.busy;
  endproperty
  a_strobe_unarmed: assert property (p_strobe_unarmed)
    else $error("unarmed strobe started a write");

  property p_spm_block;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    ctrl_wr && SELF_PROGRAM_ENABLE && !st_reg.busy |=> !st_reg.busy;
  endproperty
  a_spm_block: assert property (p_spm_block)
    else $error("write started during self-programming");

  property p_write_stall;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    write_start |=> CPU_STALL [*2] ##1 !CPU_STALL;
  endproperty
  a_write_stall: assert property (p_write_stall)
    else $error("write stall not two cycles");

  property p_read_stall;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    read_start |=> CPU_STALL [*4] ##1 !CPU_STALL;
  endproperty
  a_read_stall: assert property (p_read_stall)
    else $error("read stall not four cycles");

  property p_read_data;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    read_start |=> st_reg.data == stor_mem[$past(st_reg.addr)];
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read did not load addressed byte");

  property p_addr_locked;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    st_reg.busy && !timer_done && !RST |=> $stable(st_reg.addr);
  endproperty
  a_addr_locked: assert property (p_addr_locked)
    else $error("address changed during a write");

  property p_irq_masked;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    st_reg.busy ##1 st_reg.busy |-> !READY_IRQ;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("ready interrupt during a write");

  property p_reset_keeps_write;
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    RST && st_reg.busy && !timer_done |=> st_reg.busy && OSC_RUN;
  endproperty
  a_reset_keeps_write: assert property (p_reset_keeps_write)
    else $error("reset aborted an ongoing write");

  property p_power_down_hold;
    @(posedge CLK_SYS) disable iff (RST || PWR_ON_RST)
    st_reg.busy ##1 st_reg.busy |-> !POWER_DOWN_READY && OSC_RUN;
  endproperty
  a_power_down_hold: assert property (p_power_down_hold)
    else $error("power-down allowed during a write");

endmodule

/* File: include/eeprom_access_params.svh */
// What this block does
// - Holds 4K bytes, each byte readable and writable
// - Bytes addressed linearly from zero, 12-bit address
// - Address bits 11..0 writable, 15..12 read zero
// - Address undefined after reset; software loads it (code resets it to zero)
// - Data register supplies write byte, holds read byte
// - Control bits 7..4 always read zero
// - Ready interrupt while enabled, global on, strobe clear
// - Strobe starts write only within four armed cycles
// - Strobe without arm does nothing
// - Hardware clears arm four cycles after set
// - Strobe stays set until write period ends
// - Write lasts 8448 cycles of 1 MHz oscillator
// - Write start stalls CPU two cycles
// - Read strobe fetches byte, stalls CPU four cycles
// - No reads or address changes during a write
// - No write start while flash self-programming
// - Write continues through power-down, oscillator runs
// - Reset does not abort an ongoing write
`ifndef EEPROM_ACCESS_PARAMS_SVH
`define EEPROM_ACCESS_PARAMS_SVH

// ****************************************************************
// Register selects
// ****************************************************************
`define REG_ADDR_LOW 2'h0
`define REG_ADDR_HIGH 2'h1
`define REG_DATA 2'h2
`define REG_CONTROL 2'h3

// ****************************************************************
// Control fields
// ****************************************************************
`define CTRL_RIE 3
`define CTRL_ARM 2
`define CTRL_STROBE 1
`define CTRL_READ 0
`define ADDR_HIGH_MSB 3

// ****************************************************************
// Reset values
// ****************************************************************
`define ADDR_RESET 12'h000
`define DATA_RESET 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define ARM_CYCLES 3'h4
`define WRITE_STALL_CYCLES 3'h2
`define READ_STALL_CYCLES 3'h4
`define CLK_FREQ_HZ 32'h02faf080
`define OSC_FREQ_HZ 32'h000f4240
`define OSC_DIV (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`define WRITE_OSC_CYCLES 14'h2100
`define STORAGE_BYTES 4096

`endif

/* File: include/eeprom_access_pkg.sv */
`include "eeprom_access_params.svh"

package eeprom_access_pkg;

  // ****************************************************************
  // Controller state
  // ****************************************************************
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
    logic rie;
    logic arm;
    logic [2:0] arm_cnt;
    logic busy;
    logic [11:0] wr_addr;
    logic [7:0] wr_data;
    logic [2:0] stall_cnt;
    logic stall;
    logic irq;
    logic [7:0] rdata;
    logic osc_run;
    logic pd_ready;
  } ctrl_state_t;

  // ****************************************************************
  // Write timer state
  // ****************************************************************
  typedef struct packed {
    logic [5:0] div;
    logic [13:0] cnt;
    logic run;
    logic done;
  } timer_state_t;

endpackage

/* File: hdl/write_timer.sv */
`timescale 1ns/1ps

`include "eeprom_access_params.svh"

module write_timer
  import eeprom_access_pkg::*;
#(
  parameter logic [13:0] OSC_CYCLES = `WRITE_OSC_CYCLES
) (
  input wire logic clk,
  input wire logic por,
  input wire logic start,
  output logic done
);

  localparam logic [5:0] DIV_LAST = 6'(`OSC_DIV - 1);

  timer_state_t st_reg;
  timer_state_t st_next;
  logic tick;

  assign done = st_reg.done;
  assign tick = st_reg.run && (st_reg.div == DIV_LAST);

  // ****************************************************************
  // Oscillator divider and period counter
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (start && !st_reg.run) begin
      st_next.run = 1'b1;
      st_next.div = 6'h00;
      st_next.cnt = 14'h0000;
    end else if (st_reg.run) begin
      st_next.div = tick ? 6'h00 : st_reg.div + 6'h01;
      if (tick) begin
        if (st_reg.cnt == OSC_CYCLES - 14'h0001) begin
          st_next.run = 1'b0;
          st_next.done = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 14'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (por) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_done_at_end;
    @(posedge clk) disable iff (por)
    tick && st_reg.cnt == OSC_CYCLES - 14'h0001 |=> done && !st_reg.run;
  endproperty
  a_done_at_end: assert property (p_done_at_end)
    else $error("write period did not end on last count");

endmodule

/* File: verification/cpu_bus_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// CPU side of the register bus
// ****************************************************************
module cpu_bus_model (
  input wire logic clk,
  output logic io_we,
  output logic io_re,
  output logic [1:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  initial begin
    io_we = 1'b0;
    io_re = 1'b0;
    io_addr = 2'h0;
    io_wdata = 8'h00;
  end

  // One write access, data scrambled once released
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    io_we <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_we <= 1'b0;
    io_wdata <= ~d;
  endtask

  // One read access, data taken the cycle after
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    io_re <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_re <= 1'b0;
    #1;
    d = io_rdata;
  endtask

  // Load, arm with strobe clear, strobe two cycles later
  task automatic store(input logic [11:0] a, input logic [7:0] d,
                       input logic [7:0] ie);
    wr(2'h0, a[7:0]);
    wr(2'h1, {4'h0, a[11:8]});
    wr(2'h2, d);
    wr(2'h3, ie | 8'h04);
    wr(2'h3, ie | 8'h02);
  endtask
endmodule

/* File: verification/tb_eeprom_access_controller.sv */
`timescale 1ns/1ps

// ****************************************************************
// Bench
// ****************************************************************
module tb_eeprom_access_controller;
  import eeprom_access_pkg::*;
  logic clk_sys = 1'b0;
  logic rst, por, gie, spm, slp;
  logic io_we, io_re, cpu_stall, ready_irq, osc_run, pd_ready;
  logic [1:0] io_addr;
  logic [7:0] io_wdata, io_rdata, d;
  int fails, checks, n;

  cpu_bus_model cpu (.clk(clk_sys), .io_we(io_we), .io_re(io_re),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));

  eeprom_access_controller #(.WRITE_OSC_CYCLES(14'h0004)) dut (
    .CLK_SYS(clk_sys), .RST(rst), .PWR_ON_RST(por), .IO_WE(io_we),
    .IO_RE(io_re), .IO_ADDR(io_addr), .IO_WDATA(io_wdata),
    .IO_RDATA(io_rdata), .GLOBAL_INT_ENABLE(gie),
    .SELF_PROGRAM_ENABLE(spm), .SLEEP_POWER_DOWN(slp),
    .CPU_STALL(cpu_stall), .READY_IRQ(ready_irq), .OSC_RUN(osc_run),
    .POWER_DOWN_READY(pd_ready));

  always #10 clk_sys = ~clk_sys;

  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_up(input int c, input int lim);
    fails++;
    $display("ERROR t=%0t got=%h exp=%h", $time, c, lim);
    tally_and_finish();
  endtask

  task automatic stall_count(output int c);
    c = 0;
    #1;
    while (cpu_stall === 1'b1 && c < 9) begin
      c++;
      @(posedge clk_sys);
      #1;
    end
    if (c >= 9) begin
      give_up(c, 9);
    end
  endtask

  task automatic wait_idle(output int c);
    c = 0;
    while (osc_run !== 1'b0 && c < 400) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    if (c >= 400) begin
      give_up(c, 400);
    end
  endtask

  task automatic gap(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_regs();
    cpu.wr(2'h0, 8'hff);
    cpu.wr(2'h1, 8'hff);
    cpu.wr(2'h3, 8'hf0);
    cpu.rd(2'h1, d);
    chk(d, 8'h0f);
    cpu.rd(2'h0, d);
    chk(d, 8'hff);
    cpu.rd(2'h3, d);
    chk(d, 8'h00);
    cpu.wr(2'h2, 8'ha5);
    cpu.rd(2'h2, d);
    chk(d, 8'ha5);
    $display("t_regs done");
  endtask

  task automatic t_write_read();
    cpu.store(12'h123, 8'h5a, 8'h00);
    stall_count(n);
    chk(n[7:0], 8'h02);
    cpu.rd(2'h3, d);
    chk(d, 8'h02);
    cpu.wr(2'h0, 8'h77);
    cpu.wr(2'h3, 8'h01);
    stall_count(n);
    chk(n[7:0], 8'h00);
    cpu.wr(2'h2, 8'h11);
    wait_idle(n);
    cpu.rd(2'h0, d);
    chk(d, 8'h23);
    cpu.wr(2'h3, 8'h01);
    stall_count(n);
    chk(n[7:0], 8'h04);
    cpu.rd(2'h2, d);
    chk(d, 8'h5a);
    $display("t_write_read done");
  endtask

  task automatic t_guard();
    cpu.wr(2'h3, 8'h02);
    cpu.rd(2'h3, d);
    chk({6'h0, d[1], osc_run}, 8'h00);
    cpu.wr(2'h3, 8'h04);
    cpu.rd(2'h3, d);
    chk(d, 8'h04);
    gap(4);
    cpu.rd(2'h3, d);
    chk(d, 8'h00);
    cpu.wr(2'h2, 8'h99);
    cpu.wr(2'h3, 8'h04);
    gap(4);
    cpu.wr(2'h3, 8'h02);
    cpu.rd(2'h3, d);
    chk({6'h0, d[1], osc_run}, 8'h00);
    @(posedge clk_sys) spm <= 1'b1;
    cpu.store(12'h123, 8'h66, 8'h00);
    cpu.rd(2'h3, d);
    chk({6'h0, d[1], osc_run}, 8'h00);
    @(posedge clk_sys) spm <= 1'b0;
    cpu.wr(2'h3, 8'h01);
    cpu.rd(2'h2, d);
    chk(d, 8'h5a);
    $display("t_guard done");
  endtask

  task automatic t_reset_write();
    cpu.store(12'hfff, 8'hc3, 8'h00);
    @(posedge clk_sys) rst <= 1'b1;
    slp <= 1'b1;
    @(posedge clk_sys) rst <= 1'b0;
    gap(2);
    chk({6'h0, pd_ready, osc_run}, 8'h01);
    wait_idle(n);
    chk({7'h0, n >= 190 && n <= 205}, 8'h01);
    gap(2);
    chk({7'h0, pd_ready}, 8'h01);
    @(posedge clk_sys) slp <= 1'b0;
    cpu.wr(2'h0, 8'hff);
    cpu.wr(2'h1, 8'h0f);
    cpu.wr(2'h3, 8'h01);
    cpu.rd(2'h2, d);
    chk(d, 8'hc3);
    $display("t_reset_write done");
  endtask

  task automatic t_irq();
    @(posedge clk_sys) gie <= 1'b1;
    cpu.wr(2'h3, 8'h08);
    gap(2);
    chk({7'h0, ready_irq}, 8'h01);
    @(posedge clk_sys) gie <= 1'b0;
    gap(2);
    chk({7'h0, ready_irq}, 8'h00);
    @(posedge clk_sys) gie <= 1'b1;
    cpu.store(12'h001, 8'h3c, 8'h08);
    gap(2);
    chk({7'h0, ready_irq}, 8'h00);
    wait_idle(n);
    gap(2);
    chk({7'h0, ready_irq}, 8'h01);
    cpu.wr(2'h3, 8'h00);
    $display("t_irq done");
  endtask

  initial begin
    rst = 1'b1;
    por = 1'b1;
    gie = 1'b0;
    spm = 1'b0;
    slp = 1'b0;
    fails = 0;
    checks = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    por <= 1'b0;
    t_regs();
    t_write_read();
    t_guard();
    t_reset_write();
    t_irq();
    tally_and_finish();
  end
endmodule
